// file: vr_power_stage_model.sv
// gate driver and power stage model seen from the phase pins
`timescale 1ns/10ps
`default_nettype none
module vr_power_stage_model #(
  parameter int NPH = 6
) (
  input  wire logic [NPH-1:0] pwm_in,
  input  wire logic [NPH-1:0] pwm_oe_n_in,
  input  wire logic           spwm_in,
  input  wire logic           spwm_oe_n_in,
  input  wire logic [1:0]     drv_en_in,
  output logic [NPH:0]        hiz_out,
  output logic [NPH:0]        low_on_out
);
  // a released pin floats to mid-rail, which the driver reads as both switches off
  assign hiz_out = {spwm_oe_n_in, pwm_oe_n_in};
  // low side conducts only for a driven zero with its driver enabled
  assign low_on_out = {~spwm_oe_n_in & ~spwm_in & drv_en_in[1],
                       ~pwm_oe_n_in & ~pwm_in & {NPH{drv_en_in[0]}}};
endmodule
`default_nettype wire

// file: vr_protect_fsm.sv
// fault protection controller for a dual-section regulator
`timescale 1ns/10ps
`default_nettype none
`include "vr_protect_map.svh"

// Functional notes
// - overvoltage at sense above reference plus 175mV
// - overvoltage latches, sinks faulting section, clears ready
// - undervoltage 400mV below reference, armed above 500mV
// - undervoltage latches, all outputs high impedance
// - soft-start protected; transitions mask UV/OC plus delay
// - transition overvoltage threshold 1.8V, 2.4V with offset
// - overvoltage ramps faulting reference down to 250mV
// - faulting section alternates low/high impedance, driver on
// - other section high impedance, driver enable low
// - overvoltage drives oscillator fault pin high
// - latch cleared only by enable or power cycle
// - overvoltage sequence ends with all outputs high impedance
// - phase over current limit forces low side on
// - total overcurrent latches, everything high impedance
// - current monitor 1.24V flags maximum current
// - monitor only reports; limit input only protects
// - power state above 00h caps phases at two
// - total overcurrent level scales with state and phases
// - voltage command ramps reference at slope, retargetable
module vr_protect_fsm
  import vr_protect_pkg::*;
#(
  parameter int NPH      = 6,
  parameter int MASK_CYC = `MASK_DELAY_CYC
) (
  input  wire logic             mclk_in,
  input  wire logic             rst_in,
  input  wire apb_req_s         apb_in,
  output logic [31:0]           prdata_out,
  output logic                  pready_out,
  output logic                  pslverr_out,
  input  wire logic             enable_in,
  input  wire sense_s           sense_in,
  input  wire logic [NPH:0]     phase_info_current_in,
  input  wire logic [NPH-1:0]   pwm_req_in,
  input  wire logic             single_pwm_req_in,
  output logic [NPH-1:0]        phase_pwm_out,
  output logic [NPH-1:0]        phase_pwm_oe_n_out,
  output logic                  single_pwm_out,
  output logic                  single_pwm_oe_n_out,
  output logic [1:0]            driver_enable_out,
  output logic [1:0]            section_ready_out,
  output logic                  osc_fault_pin_out,
  output logic                  max_current_detect_out,
  output logic [2:0]            active_phases_out
);

  typedef struct packed {
    ctl_state_e       st;
    sense_s           sen1;
    sense_s           sen2;
    logic [NPH:0]     oc1;
    logic [NPH:0]     oc2;
    logic             en1;
    logic             en2;
    logic [1:0]       ps;
    logic             ofs;
    logic [2:0]       ncfg;
    logic [15:0]      slope;
    logic [15:0]      tick_cnt;
    mv_t [1:0]        vset;
    mv_t [1:0]        tgt;
    mv_t [1:0]        ref_mv;
    logic [1:0]       dvt;
    logic [1:0][11:0] mask_cnt;
    fault_kind_e      fk;
    logic             fsec;
    logic [1:0]       ready;
    logic [NPH-1:0]   pwm;
    logic [NPH-1:0]   pwm_oe_n;
    logic             spwm;
    logic             spwm_oe_n;
    logic [1:0]       drv_en;
    logic             fault_pin;
    logic             max_cur;
    logic [2:0]       act;
    logic [31:0]      prdata;
    logic             pslverr;
  } state_s;

  state_s s_r;
  state_s s_nxt;

  mv_t [1:0]       sen;
  logic [1:0]      masked;
  logic [1:0]      ov;
  logic [1:0]      uv;
  logic            toc;
  mv_t             toc_lvl;
  logic [12:0]     ovth;
  sec_mode_e [1:0] mode;
  logic            tick;
  logic            wr;
  logic            setup;
  logic [2:0]      act;

  assign sen[0] = s_r.sen2.multi_phase_voltage_sense;
  assign sen[1] = s_r.sen2.single_phase_voltage_sense;
  assign setup  = apb_in.psel & ~apb_in.penable;
  assign wr     = apb_in.psel & apb_in.penable & apb_in.pwrite;
  assign tick   = (s_r.tick_cnt == 16'h0000);

  // OC level and phase cap follow the commanded power state
  always_comb begin
    act = s_r.ncfg;
    if (s_r.ps != 2'h0 && s_r.ncfg > `PS_PHASE_CAP) begin
      act = `PS_PHASE_CAP;
    end
    toc_lvl = `TOC_PS0_MV;
    if (s_r.ps != 2'h0) begin
      unique case (s_r.ncfg)
        3'h3:    toc_lvl = `TOC_N3_MV;
        3'h4:    toc_lvl = `TOC_N4_MV;
        3'h5:    toc_lvl = `TOC_N5_MV;
        3'h6:    toc_lvl = `TOC_N6_MV;
        default: toc_lvl = `TOC_PS0_MV;
      endcase
    end
  end

  always_comb begin
    s_nxt = s_r;
    ov    = 2'b00;
    uv    = 2'b00;
    ovth  = 13'h0000;
    // inputs from the analog side cross two flops before use
    s_nxt.sen1 = sense_in;
    s_nxt.sen2 = s_r.sen1;
    s_nxt.oc1  = phase_info_current_in;
    s_nxt.oc2  = s_r.oc1;
    s_nxt.en1  = enable_in;
    s_nxt.en2  = s_r.en1;
    s_nxt.tick_cnt = tick ? ((s_r.slope == 16'h0000) ? 16'h0000 : s_r.slope - 16'h0001)
                          : s_r.tick_cnt - 16'h0001;

    for (int k = 0; k < 2; k++) begin
      masked[k] = s_r.dvt[k] | (s_r.mask_cnt[k] != 12'h000);
      // soft-start ramp leaves dvt clear so protection stays live there
      if (s_r.dvt[k]) begin
        ovth = s_r.ofs ? `OV_DVT_OFS_MV : `OV_DVT_MV;
      end else begin
        ovth = {1'b0, s_r.ref_mv[k]} + `OV_MARGIN_MV;
      end
      ov[k] = ({1'b0, sen[k]} > ovth);
      uv[k] = !masked[k] && (s_r.ref_mv[k] > `UV_ARM_MV) &&
              (({1'b0, sen[k]} + `UV_MARGIN_MV) < {1'b0, s_r.ref_mv[k]});
      // reference walks one millivolt per slope tick
      if (s_r.st != ST_OFF && tick) begin
        if (s_r.ref_mv[k] < s_r.tgt[k]) begin
          s_nxt.ref_mv[k] = s_r.ref_mv[k] + 12'h001;
        end else if (s_r.ref_mv[k] > s_r.tgt[k]) begin
          s_nxt.ref_mv[k] = s_r.ref_mv[k] - 12'h001;
        end
      end
      if (s_r.mask_cnt[k] != 12'h000) begin
        s_nxt.mask_cnt[k] = s_r.mask_cnt[k] - 12'h001;
      end
      if (s_r.dvt[k] && s_r.ref_mv[k] == s_r.tgt[k]) begin
        s_nxt.dvt[k]      = 1'b0;
        s_nxt.mask_cnt[k] = 12'(MASK_CYC);
      end
      if (s_r.st == ST_RUN && !s_r.dvt[k] && s_r.ref_mv[k] == s_r.tgt[k] &&
          s_r.tgt[k] != 12'h000) begin
        s_nxt.ready[k] = 1'b1;
      end
    end
    // limit input feeds only protection, monitor only reporting
    toc = !masked[0] && (s_r.sen2.current_limit_input >= toc_lvl);
    s_nxt.max_cur = (s_r.sen2.current_monitor >= `MAX_CUR_MV);
    s_nxt.act  = act;

    // register writes take effect at the access edge
    if (wr) begin
      unique case (apb_in.paddr)
        `REG_CTRL: begin
          s_nxt.ps   = apb_in.pwdata[`CTRL_PS_LSB +: 2];
          s_nxt.ofs  = apb_in.pwdata[`CTRL_OFS_BIT];
          s_nxt.ncfg = apb_in.pwdata[`CTRL_NPH_LSB +: 3];
        end
        `REG_VSET0, `REG_VSET1: begin
          s_nxt.vset[apb_in.paddr[3]] = apb_in.pwdata[11:0];
          if (s_r.st == ST_RUN) begin
            s_nxt.tgt[apb_in.paddr[3]] = apb_in.pwdata[11:0];
            s_nxt.dvt[apb_in.paddr[3]] = 1'b1;
          end
        end
        `REG_SLOPE: s_nxt.slope = apb_in.pwdata[15:0];
        default: ;
      endcase
    end

    unique case (s_r.st)
      ST_OFF: begin
        if (s_r.en2) begin
          s_nxt.st  = ST_RUN;
          s_nxt.tgt = s_r.vset;
        end
      end
      ST_RUN: begin
        // one fault wins per cycle: OV, then UV, then OC; section 0 first
        if (ov != 2'b00) begin
          s_nxt.st   = ST_FAULT;
          s_nxt.fk   = FK_OV;
          s_nxt.fsec = ~ov[0];
        end else if (uv != 2'b00) begin
          s_nxt.st   = ST_FAULT;
          s_nxt.fk   = FK_UV;
          s_nxt.fsec = ~uv[0];
        end else if (toc) begin
          s_nxt.st   = ST_FAULT;
          s_nxt.fk   = FK_OC;
          s_nxt.fsec = 1'b0;
        end
        if (ov != 2'b00 || uv != 2'b00 || toc) begin
          s_nxt.ready[s_nxt.fsec] = 1'b0;
          if (ov != 2'b00) begin
            s_nxt.tgt[s_nxt.fsec] = `OV_FLOOR_MV;
            s_nxt.dvt[s_nxt.fsec] = 1'b1;
          end
        end
      end
      ST_FAULT: begin
        // latched: later faults are ignored, fault record held
        s_nxt.ready[s_r.fsec] = 1'b0;
      end
      default: s_nxt.st = ST_OFF;
    endcase
    // enable low is the only way out of a latched fault
    if (!s_r.en2) begin
      s_nxt.st       = ST_OFF;
      s_nxt.fk       = FK_NONE;
      s_nxt.fsec     = 1'b0;
      s_nxt.ready    = 2'b00;
      s_nxt.dvt      = 2'b00;
      s_nxt.mask_cnt = '0;
      s_nxt.ref_mv   = '0;
      s_nxt.tgt      = '0;
    end

    // section drive modes
    for (int k = 0; k < 2; k++) begin
      mode[k] = SM_HIZ;
      if (s_r.st == ST_RUN) begin
        mode[k] = SM_NORM;
      end else if (s_r.st == ST_FAULT && s_r.fk == FK_OV && s_r.fsec == 1'(k)) begin
        mode[k] = SM_SINK;
      end
      s_nxt.drv_en[k] = (mode[k] != SM_HIZ);
    end
    for (int i = 0; i < NPH; i++) begin
      s_nxt.pwm[i]      = 1'b0;
      s_nxt.pwm_oe_n[i] = 1'b1;
      if (mode[0] == SM_NORM) begin
        if (s_r.oc2[i]) begin
          s_nxt.pwm_oe_n[i] = 1'b0;
        end else if (i < int'(act)) begin
          s_nxt.pwm[i]      = pwm_req_in[i];
          s_nxt.pwm_oe_n[i] = 1'b0;
        end
      end else if (mode[0] == SM_SINK) begin
        // sink only while above reference and floor
        s_nxt.pwm_oe_n[i] = !(sen[0] > s_r.ref_mv[0] && sen[0] >= `OV_FLOOR_MV);
      end
    end
    s_nxt.spwm      = 1'b0;
    s_nxt.spwm_oe_n = 1'b1;
    if (mode[1] == SM_NORM) begin
      s_nxt.spwm      = !s_r.oc2[NPH] && single_pwm_req_in;
      s_nxt.spwm_oe_n = 1'b0;
    end else if (mode[1] == SM_SINK) begin
      s_nxt.spwm_oe_n = !(sen[1] > s_r.ref_mv[1] && sen[1] >= `OV_FLOOR_MV);
    end
    s_nxt.fault_pin = (s_r.st == ST_FAULT) && (s_r.fk == FK_OV);

    // read data and error are loaded in the setup cycle: zero wait states
    if (setup) begin
      s_nxt.pslverr = 1'b0;
      s_nxt.prdata  = 32'h0000_0000;
      unique case (apb_in.paddr)
        `REG_CTRL:   s_nxt.prdata = {26'h0, s_r.ncfg, s_r.ofs, s_r.ps};
        `REG_VSET0:  s_nxt.prdata = {20'h0, s_r.vset[0]};
        `REG_VSET1:  s_nxt.prdata = {20'h0, s_r.vset[1]};
        `REG_SLOPE:  s_nxt.prdata = {16'h0, s_r.slope};
        `REG_STATUS: s_nxt.prdata = {19'h0, s_r.ready, s_r.act, s_r.max_cur, s_r.dvt,
                                     s_r.fsec, s_r.fk, s_r.st};
        `REG_REF:    s_nxt.prdata = {4'h0, s_r.ref_mv[1], 4'h0, s_r.ref_mv[0]};
        default:     s_nxt.pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      s_r          <= '0;
      s_r.st       <= ST_OFF;
      s_r.fk       <= FK_NONE;
      s_r.ncfg     <= `CTRL_RST_NPH;
      s_r.slope    <= `SLOPE_RST;
      s_r.pwm_oe_n <= '1;
      s_r.spwm_oe_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata_out             = s_r.prdata;
  assign pready_out             = 1'b1;
  assign pslverr_out            = s_r.pslverr & apb_in.psel & apb_in.penable;
  assign phase_pwm_out          = s_r.pwm;
  assign phase_pwm_oe_n_out     = s_r.pwm_oe_n;
  assign single_pwm_out         = s_r.spwm;
  assign single_pwm_oe_n_out    = s_r.spwm_oe_n;
  assign driver_enable_out      = s_r.drv_en;
  assign section_ready_out      = s_r.ready;
  assign osc_fault_pin_out      = s_r.fault_pin;
  assign max_current_detect_out = s_r.max_cur;
  assign active_phases_out      = s_r.act;

  a_fault_rec_held:
  assert property (@(posedge mclk_in) disable iff (rst_in)
    (s_r.st == ST_FAULT && s_r.en2) |=> (s_r.fk == $past(s_r.fk) && s_r.fsec == $past(s_r.fsec)))
    else $error("fault record changed while latched");
  a_ov_pin_high:
  assert property (@(posedge mclk_in) disable iff (rst_in)
    (s_r.st == ST_FAULT && s_r.fk == FK_OV) |=> osc_fault_pin_out)
    else $error("fault pin low during overvoltage latch");
  a_ov_other_hiz:
  assert property (@(posedge mclk_in) disable iff (rst_in)
    (s_r.st == ST_FAULT && s_r.fk == FK_OV && !s_r.fsec) ##1 (s_r.st == ST_FAULT)
      |-> (single_pwm_oe_n_out && !driver_enable_out[1] && driver_enable_out[0]))
    else $error("non-faulting section not parked");
  a_ov_floor_tgt:
  assert property (@(posedge mclk_in) disable iff (rst_in)
    (s_r.st == ST_FAULT && s_r.fk == FK_OV) |-> s_r.tgt[s_r.fsec] == `OV_FLOOR_MV)
    else $error("overvoltage target not at floor");
  a_uv_all_hiz:
  assert property (@(posedge mclk_in) disable iff (rst_in)
    (s_r.st == ST_FAULT && s_r.fk != FK_OV) [*2] |-> (&phase_pwm_oe_n_out && single_pwm_oe_n_out
      && driver_enable_out == 2'b00))
    else $error("outputs driven after non-OV latch");
  a_ready_other_kept:
  assert property (@(posedge mclk_in) disable iff (rst_in)
    ($rose(s_r.st == ST_FAULT) && $past(s_r.ready[1]) && !s_r.fsec && s_r.en2)
      |-> (s_r.ready[1] && !s_r.ready[0]))
    else $error("wrong ready output cleared");
  a_ps_phase_cap:
  assert property (@(posedge mclk_in) disable iff (rst_in)
    (s_r.ps != 2'h0 && $stable(s_r.ps) && $stable(s_r.ncfg)) |=> active_phases_out <= `PS_PHASE_CAP)
    else $error("phase count not capped");
  a_max_current_detect_detect:
  assert property (@(posedge mclk_in) disable iff (rst_in)
    (s_r.sen2.current_monitor >= `MAX_CUR_MV) |=> max_current_detect_out)
    else $error("maximum current not flagged");
  a_ov_sink_low:
  assert property (@(posedge mclk_in) disable iff (rst_in)
    (s_r.st == ST_FAULT && s_r.fk == FK_OV) [*2] |-> (&(phase_pwm_oe_n_out | ~phase_pwm_out)
      && (single_pwm_oe_n_out || !single_pwm_out)))
    else $error("pwm driven high during overvoltage");
  a_mask_delay:
  assert property (@(posedge mclk_in) disable iff (rst_in)
    ($fell(s_r.dvt[0]) && s_r.en2 && s_r.st == ST_RUN) |-> s_r.mask_cnt[0] == 12'(MASK_CYC))
    else $error("mask delay not armed");

endmodule
`default_nettype wire

// file: vr_protect_fsm_tb.sv
// self-checking bench for the protection controller
`timescale 1ns/10ps
`default_nettype none
`include "vr_protect_map.svh"
module vr_protect_fsm_tb
  import vr_protect_pkg::*;
();
  logic        mclk_in;
  logic        rst_in;
  apb_req_s    apb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        enable;
  sense_s      sense;
  logic [6:0]  info;
  logic [5:0]  pwm_req;
  logic        spwm_req;
  logic [5:0]  pwm;
  logic [5:0]  pwm_oe_n;
  logic        spwm;
  logic        spwm_oe_n;
  logic [1:0]  drv_en;
  logic [1:0]  ready;
  logic        fault_pin;
  logic        max_cur;
  logic [2:0]  act_ph;
  logic [6:0]  high_impedance;
  logic [6:0]  low_on;
  logic [31:0] rd;
  logic        err;
  int          fail_count;
  int          n_tests;
  logic [11:0] lvl [5] = '{12'h9C4, 12'h672, 12'h4E2, 12'h3E8, 12'h33E};
  logic [1:0]  ps [5]  = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h2};
  logic [2:0]  nph [5] = '{3'h6, 3'h3, 3'h4, 3'h5, 3'h6};

  vr_protect_fsm #(.NPH(6), .MASK_CYC(8)) DUT (
    .mclk_in(mclk_in), .rst_in(rst_in), .apb_in(apb), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .enable_in(enable), .sense_in(sense),
    .phase_info_current_in(info), .pwm_req_in(pwm_req), .single_pwm_req_in(spwm_req),
    .phase_pwm_out(pwm), .phase_pwm_oe_n_out(pwm_oe_n), .single_pwm_out(spwm),
    .single_pwm_oe_n_out(spwm_oe_n), .driver_enable_out(drv_en),
    .section_ready_out(ready), .osc_fault_pin_out(fault_pin),
    .max_current_detect_out(max_cur), .active_phases_out(act_ph));

  vr_power_stage_model #(.NPH(6)) stage (
    .pwm_in(pwm), .pwm_oe_n_in(pwm_oe_n), .spwm_in(spwm), .spwm_oe_n_in(spwm_oe_n),
    .drv_en_in(drv_en), .hiz_out(high_impedance), .low_on_out(low_on));

  initial begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
  endtask

  // starts on an edge, so a release and the next setup never share a time step
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    int k;
    k = 0;
    @(posedge mclk_in);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
    @(posedge mclk_in);
    apb.penable <= 1'b1;
    do begin
      @(posedge mclk_in);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    apb <= '0;
  endtask

  task automatic wait_ready(input logic [1:0] exp);
    int k;
    k = 0;
    while (ready !== exp && k < 3000) begin
      @(posedge mclk_in);
      k++;
    end
    chk("ready", {30'h0, ready}, {30'h0, exp});
  endtask

  task automatic wait_ref(input logic [11:0] exp);
    int k;
    k = 0;
    do begin
      xfer(1'b0, `REG_REF, 32'h0);
      k++;
    end while (rd[11:0] !== exp && k < 500);
    chk("ref0", {20'h0, rd[11:0]}, {20'h0, exp});
  endtask

  task automatic start(input logic [31:0] ctrl);
    @(posedge mclk_in);
    enable <= 1'b0;
    sense <= '{12'h096, 12'h096, 12'h000, 12'h000};
    cyc(8);
    chk("off_hiz", {25'h0, high_impedance}, 32'h7F);
    xfer(1'b1, `REG_CTRL, ctrl);
    xfer(1'b1, `REG_SLOPE, 32'h1);
    xfer(1'b1, `REG_VSET0, 32'h190);
    xfer(1'b1, `REG_VSET1, 32'h190);
    @(posedge mclk_in);
    enable <= 1'b1;
    wait_ready(2'b11);
  endtask

  initial begin
    repeat (40000) @(posedge mclk_in);
    fail_count++;
    complete_run();
  end

  initial begin
    rst_in = 1'b1;
    apb = '0;
    enable = 1'b0;
    sense = '0;
    info = '0;
    pwm_req = '0;
    spwm_req = 1'b0;
    fail_count = 0;
    n_tests = 0;
    cyc(12);
    chk("rst_hiz", {20'h0, high_impedance, drv_en, ready, fault_pin}, 32'hFE0);
    rst_in <= 1'b0;
    xfer(1'b0, `REG_CTRL, 32'h0);
    chk("ctrl_rst", rd, 32'h30);
    xfer(1'b0, `REG_SLOPE, 32'h0);
    chk("slope_rst", rd, 32'hC8);
    xfer(1'b0, 8'h18, 32'h0);
    chk("unmapped", {31'h0, err}, 32'h1);
    xfer(1'b1, `REG_STATUS, 32'hFFFF);
    xfer(1'b0, `REG_STATUS, 32'h0);
    chk("status_ro", {30'h0, rd[1:0]}, 32'h0);
    // per-phase limit on phase 2 and on the single phase
    start(32'h30);
    pwm_req <= 6'h3F;
    spwm_req <= 1'b1;
    info <= 7'h44;
    cyc(6);
    chk("ph_oc", {25'h0, spwm, pwm}, 32'h3B);
    info <= 7'h00;
    sense.current_monitor <= 12'h4D8;
    cyc(6);
    chk("ph_oc_end", {25'h0, spwm, pwm}, 32'h7F);
    chk("max_current_detect_hi", {31'h0, max_cur}, 32'h1);
    sense.current_monitor <= 12'h4D7;
    cyc(6);
    chk("max_current_detect_lo", {31'h0, max_cur}, 32'h0);
    // total limit pulse inside a transition must not trip
    xfer(1'b1, `REG_VSET0, 32'h320);
    sense.multi_phase_voltage_sense <= 12'h190;
    sense.current_limit_input <= 12'h9C4;
    cyc(40);
    chk("mask_oc", {30'h0, ready}, 32'h3);
    sense.current_limit_input <= 12'h000;
    wait_ref(12'h320);
    cyc(20);
    chk("uv_edge", {30'h0, ready}, 32'h3);
    sense.multi_phase_voltage_sense <= 12'h18F;
    cyc(6);
    chk("uv_rdy", {22'h0, high_impedance, fault_pin, ready}, 32'h3FA);
    xfer(1'b0, `REG_STATUS, 32'h0);
    chk("uv_stat", {27'h0, rd[4:0]}, 32'h0B);
    sense.current_limit_input <= 12'h9C4;
    cyc(20);
    xfer(1'b0, `REG_STATUS, 32'h0);
    chk("sticky", {27'h0, rd[4:0]}, 32'h0B);
    // total limit level over power state and phase count
    for (int i = 0; i < 5; i++) begin
      start({26'h0, nph[i], 1'b0, ps[i]});
      chk("phases", {29'h0, act_ph}, (ps[i] == 2'h0) ? {29'h0, nph[i]} : 32'h2);
      sense.current_limit_input <= lvl[i] - 12'h1;
      cyc(8);
      chk("toc_below", {30'h0, ready}, 32'h3);
      sense.current_limit_input <= lvl[i];
      cyc(6);
      chk("toc_trip", {23'h0, high_impedance, ready}, 32'h1FE);
    end
    // transition overvoltage level, plain and with offset
    for (int j = 0; j < 2; j++) begin
      start(j ? 32'h34 : 32'h30);
      xfer(1'b1, `REG_VSET0, 32'h320);
      sense.multi_phase_voltage_sense <= j ? 12'h960 : 12'h708;
      cyc(8);
      chk("dvt_ov_edge", {31'h0, fault_pin}, 32'h0);
      sense.multi_phase_voltage_sense <= j ? 12'h961 : 12'h709;
      cyc(6);
      chk("dvt_ov", {31'h0, fault_pin}, 32'h1);
    end
    // overvoltage sequence on the multi-phase section
    start(32'h30);
    sense.multi_phase_voltage_sense <= 12'h23F;
    cyc(8);
    chk("ov_edge", {30'h0, ready}, 32'h3);
    sense.multi_phase_voltage_sense <= 12'h240;
    cyc(6);
    chk("ov_pin", {31'h0, fault_pin}, 32'h1);
    chk("ov_rdy", {30'h0, ready}, 32'h2);
    chk("ov_drv", {30'h0, drv_en}, 32'h1);
    chk("ov_low", {25'h0, high_impedance[6], low_on[5:0]}, 32'h7F);
    xfer(1'b0, `REG_STATUS, 32'h0);
    chk("ov_stat", {27'h0, rd[4:0]}, 32'h07);
    sense.current_limit_input <= 12'h9C4;
    wait_ref(12'h0FA);
    xfer(1'b0, `REG_STATUS, 32'h0);
    chk("ov_sticky", {27'h0, rd[4:0]}, 32'h07);
    sense.multi_phase_voltage_sense <= 12'h0C8;
    cyc(6);
    chk("ov_end", {24'h0, fault_pin, high_impedance}, 32'hFF);
    // overvoltage on the single-phase section parks the multi-phase one
    start(32'h30);
    sense.single_phase_voltage_sense <= 12'h240;
    cyc(6);
    chk("ov1_rdy", {30'h0, ready}, 32'h1);
    chk("ov1_drv", {30'h0, drv_en}, 32'h2);
    chk("ov1_pins", {24'h0, high_impedance[6], low_on[6], pwm_oe_n}, 32'h7F);
    chk("ov1_pin", {31'h0, fault_pin}, 32'h1);
    xfer(1'b0, `REG_STATUS, 32'h0);
    chk("ov1_stat", {27'h0, rd[4:0]}, 32'h17);
    start(32'h30);
    complete_run();
  end
endmodule
`default_nettype wire

// file: vr_protect_map.svh
// register map, field positions, thresholds and timing constants
`ifndef VR_PROTECT_MAP_SVH
`define VR_PROTECT_MAP_SVH
`define REG_CTRL        8'h00
`define REG_VSET0       8'h04
`define REG_VSET1       8'h08
`define REG_SLOPE       8'h0C
`define REG_STATUS      8'h10
`define REG_REF         8'h14
`define CTRL_PS_LSB     0
`define CTRL_OFS_BIT    2
`define CTRL_NPH_LSB    3
`define CTRL_RST_NPH    3'h6
`define SLOPE_RST       16'h00C8
`define OV_MARGIN_MV    13'h00AF
`define OV_DVT_MV       13'h0708
`define OV_DVT_OFS_MV   13'h0960
`define UV_MARGIN_MV    13'h0190
`define UV_ARM_MV       12'h1F4
`define OV_FLOOR_MV     12'h0FA
`define TOC_PS0_MV      12'h9C4
`define TOC_N3_MV       12'h672
`define TOC_N4_MV       12'h4E2
`define TOC_N5_MV       12'h3E8
`define TOC_N6_MV       12'h33E
`define MAX_CUR_MV      12'h4D8
`define PS_PHASE_CAP    3'h2
`define MASK_DELAY_NS   10000
`define CLK_MHZ         200
`define MASK_DELAY_CYC  ((`MASK_DELAY_NS * `CLK_MHZ + 999) / 1000)
`endif

// file: vr_protect_pkg.sv
// types shared by the protection controller and its bench
package vr_protect_pkg;
  typedef logic [11:0] mv_t;
  typedef enum logic [1:0] {ST_OFF = 2'b00, ST_RUN = 2'b01, ST_FAULT = 2'b11} ctl_state_e;
  typedef enum logic [1:0] {FK_NONE = 2'b00, FK_OV = 2'b01, FK_UV = 2'b10, FK_OC = 2'b11} fault_kind_e;
  typedef enum logic [1:0] {SM_HIZ = 2'b00, SM_NORM = 2'b01, SM_SINK = 2'b11} sec_mode_e;
  typedef struct packed {
    mv_t multi_phase_voltage_sense;
    mv_t single_phase_voltage_sense;
    mv_t current_limit_input;
    mv_t current_monitor;
  } sense_s;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_s;
endpackage
